// ---- src/imr_master_rx.sv ----
// Purpose: i2c master start, address, receive, acknowledge and stop engine
// Assumes: open-drain pins resolved outside; scl and sda sampled from pins
// Notes: one command at a time; flags are sticky until cleared
`timescale 1ns/1ns
module imr_master_rx (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   // commands from software, one-cycle pulses; ack_data_bit_i and brg_reload_i are held levels
   input wire logic start_enable_bit_i,
   input wire logic receive_enable_bit_i,
   input wire logic ack_sequence_enable_i,
   input wire logic stop_enable_i,
   input wire logic ack_data_bit_i,
   input wire logic [imr_pkg::BRG_W-1:0] brg_reload_i,
   // data buffer access
   input wire logic buf_wr_i,
   input wire logic [imr_pkg::DATA_W-1:0] buf_wr_data_i,
   input wire logic buf_rd_i,
   // flag clears, one-cycle pulses
   input wire logic int_clr_i,
   input wire logic ovf_clr_i,
   input wire logic write_collision_flag_clr_i,
   // status
   output logic [imr_pkg::DATA_W-1:0] port_data_buffer_o,
   output logic buffer_full_flag_o,
   output logic rx_avail_o,
   output logic port_interrupt_flag_o,
   output logic receive_overflow_flag_o,
   output logic write_collision_flag_o,
   output logic ack_status_bit_o,
   output logic receive_enable_bit_o,
   output logic start_enable_bit_o,
   output logic ack_sequence_enable_o,
   output logic busy_o,
   // i2c pins, open drain
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   imr_pkg::imr_state_t state_ff;
   logic [1:0] scl_sync_ff;
   logic [1:0] sda_sync_ff;
   logic [imr_pkg::BRG_W-1:0] brg_cnt_ff;
   logic [3:0] bit_cnt_ff;
   logic phase_ff;
   logic [imr_pkg::DATA_W-1:0] tx_sh_ff;
   logic [imr_pkg::DATA_W-1:0] receive_shift_register_ff;
   logic scl_low_ff;
   logic sda_low_ff;
   logic bf_ff;
   logic int_ff;
   logic ovf_ff;
   logic write_collision_flag_ff;
   logic ack_status_bit_ff;
   logic receive_enable_bit_ff;
   logic sen_ff;
   logic ack_sequence_enable_ff;
   logic busy_ff;
   logic [imr_pkg::DATA_W-1:0] buf_data_ff;
   logic avail_ff;
   logic idle;
   logic brg_run;
   logic stretch;
   logic tick;
   logic rise_end;
   logic byte_done;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [imr_pkg::DATA_W-1:0] fifo_out_data;
   logic push_ok;
   logic ev_done;
   logic [3:0] nxt_bit;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   // two stages each; only stage one reads the pin
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         scl_sync_ff <= 2'h3;
         sda_sync_ff <= 2'h3;
      end
      else
      begin
         scl_sync_ff <= {scl_sync_ff[0], scl_i};
         sda_sync_ff <= {sda_sync_ff[0], sda_i};
      end
   end

   // ------------------------------------------------------------
   // baud rate generator
   // ------------------------------------------------------------
   assign idle = (state_ff == imr_pkg::ST_IDLE);
   // counter suspended in idle and while a byte waits for fifo room
   assign brg_run = ~idle & (state_ff != imr_pkg::ST_PUSH);
   // a slave holding scl low stretches the high phase
   assign stretch = ~scl_low_ff & ~scl_sync_ff[1];
   assign tick = brg_run & ~stretch & (brg_cnt_ff == '0);
   assign rise_end = tick & phase_ff;
   assign nxt_bit = bit_cnt_ff + 4'h1;

   // reload on rollover so each half period is reload+1 clocks
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         brg_cnt_ff <= '0;
      end
      else if (!brg_run || tick)
      begin
         brg_cnt_ff <= brg_reload_i;
      end
      else if (!stretch)
      begin
         brg_cnt_ff <= brg_cnt_ff - 1'b1;
      end
   end

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   // byte end is the falling edge after the eighth high phase
   assign byte_done = rise_end & (bit_cnt_ff == imr_pkg::LAST_DATA_BIT);
   assign fifo_in_valid = (state_ff == imr_pkg::ST_PUSH);
   assign push_ok = fifo_in_valid & fifo_in_ready;

   // command acceptance only from idle, later requests are dropped
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         state_ff <= imr_pkg::ST_IDLE;
         bit_cnt_ff <= imr_pkg::STEP_FIRST;
         phase_ff <= 1'b0;
      end
      else
      begin
         unique case (state_ff)
            imr_pkg::ST_IDLE:
            begin
               bit_cnt_ff <= imr_pkg::STEP_FIRST;
               phase_ff <= 1'b0;
               if (start_enable_bit_i)
               begin
                  state_ff <= imr_pkg::ST_START;
               end
               else if (buf_wr_i)
               begin
                  state_ff <= imr_pkg::ST_TX;
               end
               else if (receive_enable_bit_i)
               begin
                  state_ff <= imr_pkg::ST_RX;
               end
               else if (ack_sequence_enable_i)
               begin
                  state_ff <= imr_pkg::ST_ACK;
               end
               else if (stop_enable_i)
               begin
                  state_ff <= imr_pkg::ST_STOP;
               end
            end
            imr_pkg::ST_START,
            imr_pkg::ST_STOP:
            begin
               if (tick)
               begin
                  bit_cnt_ff <= nxt_bit;
                  if (bit_cnt_ff == imr_pkg::STEP_LAST)
                  begin
                     state_ff <= imr_pkg::ST_IDLE;
                  end
               end
            end
            imr_pkg::ST_TX,
            imr_pkg::ST_RX,
            imr_pkg::ST_ACK:
            begin
               if (tick)
               begin
                  phase_ff <= ~phase_ff;
               end
               if (rise_end)
               begin
                  bit_cnt_ff <= nxt_bit;
                  if ((state_ff == imr_pkg::ST_TX) && (bit_cnt_ff == imr_pkg::ACK_BIT))
                  begin
                     state_ff <= imr_pkg::ST_IDLE;
                  end
                  else if ((state_ff == imr_pkg::ST_RX) && byte_done)
                  begin
                     state_ff <= imr_pkg::ST_PUSH;
                  end
                  else if (state_ff == imr_pkg::ST_ACK)
                  begin
                     state_ff <= imr_pkg::ST_IDLE;
                  end
               end
            end
            imr_pkg::ST_PUSH:
            begin
               // stalls with scl low until the fifo takes the byte
               if (fifo_in_ready)
               begin
                  state_ff <= imr_pkg::ST_IDLE;
               end
            end
            default:
            begin
               state_ff <= imr_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // shift registers
   // ------------------------------------------------------------
   // msb first both ways; receive register cleared at each new byte
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         tx_sh_ff <= imr_pkg::DATA_RST;
         receive_shift_register_ff <= imr_pkg::DATA_RST;
      end
      else if (idle)
      begin
         if (buf_wr_i && !start_enable_bit_i)
         begin
            tx_sh_ff <= buf_wr_data_i;
         end
         if (receive_enable_bit_i)
         begin
            receive_shift_register_ff <= imr_pkg::DATA_RST;
         end
      end
      else if (rise_end)
      begin
         tx_sh_ff <= {tx_sh_ff[imr_pkg::DATA_W-2:0], 1'b1};
         if (state_ff == imr_pkg::ST_RX)
         begin
            receive_shift_register_ff <=
               {receive_shift_register_ff[imr_pkg::DATA_W-2:0], sda_sync_ff[1]};
         end
      end
   end

   // ------------------------------------------------------------
   // pin drive
   // ------------------------------------------------------------
   // sda only moves while scl is low; start and stop move it with scl high
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         scl_low_ff <= 1'b0;
         sda_low_ff <= 1'b0;
      end
      else
      begin
         unique case (state_ff)
            imr_pkg::ST_IDLE:
            begin
               if (buf_wr_i && !start_enable_bit_i)
               begin
                  sda_low_ff <= ~buf_wr_data_i[imr_pkg::DATA_W-1];
               end
               else if (receive_enable_bit_i)
               begin
                  sda_low_ff <= 1'b0;
               end
               // same ranking as the sequencer, except that a receive with a start in the same cycle still releases sda
               else if (ack_sequence_enable_i && !start_enable_bit_i)
               begin
                  sda_low_ff <= ~ack_data_bit_i;
               end
               else if (stop_enable_i && !start_enable_bit_i)
               begin
                  sda_low_ff <= 1'b1;
               end
            end
            imr_pkg::ST_START:
            begin
               if (tick)
               begin
                  unique case (bit_cnt_ff)
                     imr_pkg::STEP_FIRST: sda_low_ff <= 1'b1;
                     imr_pkg::STEP_MID: scl_low_ff <= 1'b1;
                     default: scl_low_ff <= 1'b1;
                  endcase
               end
            end
            imr_pkg::ST_STOP:
            begin
               if (tick)
               begin
                  unique case (bit_cnt_ff)
                     imr_pkg::STEP_FIRST: scl_low_ff <= 1'b0;
                     imr_pkg::STEP_MID: sda_low_ff <= 1'b0;
                     default: sda_low_ff <= 1'b0;
                  endcase
               end
            end
            imr_pkg::ST_TX,
            imr_pkg::ST_RX,
            imr_pkg::ST_ACK:
            begin
               if (tick)
               begin
                  scl_low_ff <= phase_ff;
               end
               if (rise_end)
               begin
                  // next bit, or release for the slave ack and for reception
                  if ((state_ff == imr_pkg::ST_TX) && (bit_cnt_ff < imr_pkg::LAST_DATA_BIT))
                  begin
                     sda_low_ff <= ~tx_sh_ff[imr_pkg::DATA_W-2];
                  end
                  else
                  begin
                     sda_low_ff <= 1'b0;
                  end
               end
            end
            imr_pkg::ST_PUSH:
            begin
               scl_low_ff <= 1'b1;
            end
            default:
            begin
               scl_low_ff <= scl_low_ff;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // status flags
   // ------------------------------------------------------------
   // completion of start, address, ack or stop
   assign ev_done = rise_end & ((state_ff == imr_pkg::ST_ACK) |
                    ((state_ff == imr_pkg::ST_TX) & (bit_cnt_ff == imr_pkg::ACK_BIT)))
                    | (tick & (bit_cnt_ff == imr_pkg::STEP_LAST) &
                    ((state_ff == imr_pkg::ST_START) | (state_ff == imr_pkg::ST_STOP)));

   // every sticky flag: a set in the clear cycle wins
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         int_ff <= 1'b0;
         bf_ff <= 1'b0;
         ovf_ff <= 1'b0;
         write_collision_flag_ff <= 1'b0;
         ack_status_bit_ff <= 1'b0;
      end
      else
      begin
         int_ff <= ev_done | push_ok | (int_ff & ~int_clr_i);
         bf_ff <= push_ok | (bf_ff & ~buf_rd_i);
         ovf_ff <= (push_ok & bf_ff & ~buf_rd_i) | (ovf_ff & ~ovf_clr_i);
         write_collision_flag_ff <= (buf_wr_i & ~idle) | (write_collision_flag_ff & ~write_collision_flag_clr_i);
         if (rise_end && (state_ff == imr_pkg::ST_TX) && (bit_cnt_ff == imr_pkg::ACK_BIT))
         begin
            ack_status_bit_ff <= sda_sync_ff[1];
         end
      end
   end

   // command bits mirror the running operation
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         receive_enable_bit_ff <= 1'b0;
         sen_ff <= 1'b0;
         ack_sequence_enable_ff <= 1'b0;
         busy_ff <= 1'b0;
      end
      else
      begin
         if (idle && receive_enable_bit_i && !start_enable_bit_i && !buf_wr_i)
         begin
            receive_enable_bit_ff <= 1'b1;
         end
         else if (push_ok)
         begin
            receive_enable_bit_ff <= 1'b0;
         end
         if (idle && start_enable_bit_i)
         begin
            sen_ff <= 1'b1;
         end
         else if (ev_done)
         begin
            sen_ff <= 1'b0;
         end
         if (idle && ack_sequence_enable_i && !start_enable_bit_i && !buf_wr_i &&
             !receive_enable_bit_i)
         begin
            ack_sequence_enable_ff <= 1'b1;
         end
         else if (ev_done)
         begin
            ack_sequence_enable_ff <= 1'b0;
         end
         busy_ff <= ~idle;
      end
   end

   // ------------------------------------------------------------
   // receive fifo and data buffer
   // ------------------------------------------------------------
   imr_fifo #(
      .WIDTH(imr_pkg::DATA_W),
      .DEPTH(imr_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_sys_i(clk_sys_i),
      .arst_n_i(arst_n_i),
      .in_valid_i(fifo_in_valid),
      .in_data_i(receive_shift_register_ff),
      .in_ready_o(fifo_in_ready),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(buf_rd_i),
      .out_data_o(fifo_out_data)
   );

   // registered head word; a read shows the next byte one cycle later
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         buf_data_ff <= imr_pkg::DATA_RST;
         avail_ff <= 1'b0;
      end
      else
      begin
         if (fifo_out_valid)
         begin
            buf_data_ff <= fifo_out_data;
         end
         avail_ff <= fifo_out_valid;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign port_data_buffer_o = buf_data_ff;
   assign buffer_full_flag_o = bf_ff;
   assign rx_avail_o = avail_ff;
   assign port_interrupt_flag_o = int_ff;
   assign receive_overflow_flag_o = ovf_ff;
   assign write_collision_flag_o = write_collision_flag_ff;
   assign ack_status_bit_o = ack_status_bit_ff;
   assign receive_enable_bit_o = receive_enable_bit_ff;
   assign start_enable_bit_o = sen_ff;
   assign ack_sequence_enable_o = ack_sequence_enable_ff;
   assign busy_o = busy_ff;
   assign scl_oe_o = scl_low_ff;
   assign sda_oe_o = sda_low_ff;
   // open drain: the data level is always low, only the enable moves
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;

endmodule

// ---- src/imr_pkg.sv ----
// Purpose: shared constants and types for the i2c master receive block
// Assumes: 8-bit data path, baud counter reload supplied by software
// Notes: counts are in baud generator rollovers, not system clocks
package imr_pkg;

   // ------------------------------------------------------------
   // data path
   // ------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int BRG_W = 7;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

   // ------------------------------------------------------------
   // bit and step positions
   // ------------------------------------------------------------
   localparam logic [3:0] LAST_DATA_BIT = 4'h7; // eighth bit, index 7
   localparam logic [3:0] ACK_BIT = 4'h8;       // ninth clock of a byte
   localparam logic [3:0] STEP_FIRST = 4'h0;
   localparam logic [3:0] STEP_MID = 4'h1;
   localparam logic [3:0] STEP_LAST = 4'h2;

   // ------------------------------------------------------------
   // sequencer states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_START,
      ST_TX,
      ST_RX,
      ST_PUSH,
      ST_ACK,
      ST_STOP
   } imr_state_t;

endpackage

// ---- src/imr_fifo.sv ----
// Purpose: small synchronous fifo for received bytes
// Assumes: single clock, push and pop may happen in one cycle
// Notes: read data is the head word, valid while out_valid_o is high
`timescale 1ns/1ns
module imr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   // filling side
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   // draining side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [AW:0] count_ff;
   logic push;
   logic pop;

   // honest flags straight from the occupancy count
   assign in_ready_o = (count_ff != (AW+1)'(DEPTH));
   assign out_valid_o = (count_ff != '0);
   assign push = in_valid_i & in_ready_o;
   assign pop = out_ready_i & out_valid_o;
   assign out_data_o = mem[rd_ptr_ff];

   // storage has no reset, only pointers and count do
   always_ff @(posedge clk_sys_i)
   begin
      if (push)
      begin
         mem[wr_ptr_ff] <= in_data_i;
      end
   end

   // pointers wrap because depth is a power of two
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
         end
         if (push & ~pop)
         begin
            count_ff <= count_ff + 1'b1;
         end
         else if (pop & ~push)
         begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end

endmodule

// ---- bench/imr_monitor.sv ----
// Purpose: port-level checks for the i2c master receive engine
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound to the engine from the bench top file
`timescale 1ns/1ns
module imr_monitor (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   // commands
   input wire logic receive_enable_bit_i,
   input wire logic buf_wr_i,
   input wire logic buf_rd_i,
   input wire logic ack_data_bit_i,
   // status and pins
   input wire logic [imr_pkg::DATA_W-1:0] port_data_buffer_o,
   input wire logic buffer_full_flag_o,
   input wire logic port_interrupt_flag_o,
   input wire logic receive_overflow_flag_o,
   input wire logic write_collision_flag_o,
   input wire logic receive_enable_bit_o,
   input wire logic start_enable_bit_o,
   input wire logic ack_sequence_enable_o,
   input wire logic scl_oe_o,
   input wire logic sda_oe_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);
   // ------------------------------------------------------------
   // command acceptance and flags
   // ------------------------------------------------------------
   chk_receive_enable_bit_idle: assert property (
      start_enable_bit_o && receive_enable_bit_i |=> !receive_enable_bit_o)
      else $error("receive taken while busy");
   chk_full_rise: assert property (
      $rose(buffer_full_flag_o) |-> port_interrupt_flag_o && !receive_enable_bit_o)
      else $error("full without interrupt");
   chk_read_clear: assert property (
      buf_rd_i && !receive_enable_bit_o |=> !buffer_full_flag_o)
      else $error("read left full set");
   chk_ovf_set: assert property (
      $fell(receive_enable_bit_o) && $past(buffer_full_flag_o) && !$past(buf_rd_i)
      |-> receive_overflow_flag_o)
      else $error("overflow missed");
   // a dropped write must not touch the head word
   chk_write_collision_flag_drop: assert property (
      buf_wr_i && receive_enable_bit_o |=> write_collision_flag_o
      && $stable(port_data_buffer_o))
      else $error("collision missed");
   // ------------------------------------------------------------
   // pin behaviour
   // ------------------------------------------------------------
   chk_scl_held: assert property (
      $fell(receive_enable_bit_o) |-> scl_oe_o [*3])
      else $error("scl not held low");
   chk_rx_sda_free: assert property (
      receive_enable_bit_o |-> !sda_oe_o)
      else $error("sda driven in receive");
   chk_ack_value: assert property (
      ack_sequence_enable_o && !scl_oe_o |-> sda_oe_o == !ack_data_bit_i)
      else $error("wrong ack level");
   chk_ack_int: assert property (
      $fell(ack_sequence_enable_o) |-> port_interrupt_flag_o && !sda_oe_o)
      else $error("ack end wrong");
   chk_start_int: assert property (
      $fell(start_enable_bit_o) |-> port_interrupt_flag_o && scl_oe_o && sda_oe_o)
      else $error("start end wrong");
endmodule

// ---- bench/imr_slave_model.sv ----
// Purpose: behavioural i2c slave answering a read
// Assumes: lines resolved with pull-ups by the bench
// Notes: slow_i stretches scl by 40 ns after each fall
`timescale 1ns/1ns
module imr_slave_model (
   // bus lines
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_pull_o,
   output logic sda_pull_o,
   // data and capture
   input wire logic slow_i,
   input wire logic [7:0] tx_i,
   output logic [7:0] addr_o
);
   int ph = 0;
   int j = 0;
   logic [7:0] sh = 8'h00;
   initial
   begin
      scl_pull_o = 0;
      sda_pull_o = 0;
      addr_o = 8'h00;
   end
   // start or stop: sda moving while scl is high; the short wait lets an scl
   // fall in the same step settle, so a data change on that edge is no condition
   always @(sda_i)
   begin
      #1;
      if (scl_i)
      begin
         ph = sda_i ? 0 : 1;
         j = -1;
      end
   end
   // capture on rising scl; a master nack ends the read
   always @(posedge scl_i)
   begin
      if (ph == 1 && j < 8)
         addr_o = {addr_o[6:0], sda_i};
      if (ph == 2 && j == 0 && sda_i)
         ph = 0;
   end
   // drive only after a falling scl, so data never moves while high
   always @(negedge scl_i)
   begin
      if (ph == 1)
      begin
         j = j + 1;
         sda_pull_o = (j == 8);
         if (j == 9)
         begin
            ph = 2;
            j = 0;
         end
      end
      if (ph == 2)
      begin
         if (j == 0)
            sh = tx_i;
         sda_pull_o = (j < 8) && !sh[7 - j];
         j = (j == 8) ? 0 : j + 1;
      end
      if (slow_i)
      begin
         scl_pull_o = 1;
         #40 scl_pull_o = 0;
      end
   end
endmodule

// ---- bench/tb_top.sv ----
// Purpose: self-checking bench for the i2c master receive engine
// Assumes: pull-ups on both lines, baud reload of one
// Notes: driver queues expected bytes, a watcher checks each read
`timescale 1ns/1ns
module tb_top;
   logic clk_sys_i = 0;
   logic arst_n_i = 0;
   logic s_en = 0, r_en = 0, a_en = 0, p_en = 0, a_d = 0, wr = 0, rd = 0;
   logic i_clr = 0, o_clr = 0, w_clr = 0, slow = 0;
   logic [7:0] wdat = 8'h00, tx = 8'h00, q[$];
   logic [31:0] seed = 32'h74E0;
   wire [7:0] dbuf, addr_seen;
   wire bf, rxav, irq, ovf, write_collision_flag, ackst, receive_enable_bit, start_enable_bit, aen, scl_oe, sda_oe, scl_p, sda_p, busy;
   wire scl_ln = !(scl_oe | scl_p);
   wire sda_ln = !(sda_oe | sda_p);
   int error_cnt = 0, comparisons = 0;
   // free-running system clock
   always #4 clk_sys_i = !clk_sys_i;
   imr_master_rx i_imr_master_rx (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
      .start_enable_bit_i(s_en), .receive_enable_bit_i(r_en), .ack_sequence_enable_i(a_en),
      .stop_enable_i(p_en), .ack_data_bit_i(a_d), .brg_reload_i(7'h01), .buf_wr_i(wr),
      .buf_wr_data_i(wdat), .buf_rd_i(rd), .int_clr_i(i_clr), .ovf_clr_i(o_clr),
      .write_collision_flag_clr_i(w_clr), .port_data_buffer_o(dbuf), .buffer_full_flag_o(bf),
      .rx_avail_o(rxav), .port_interrupt_flag_o(irq), .receive_overflow_flag_o(ovf),
      .write_collision_flag_o(write_collision_flag), .ack_status_bit_o(ackst), .receive_enable_bit_o(receive_enable_bit),
      .start_enable_bit_o(start_enable_bit), .ack_sequence_enable_o(aen), .busy_o(busy), .scl_i(scl_ln),
      .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda_ln), .sda_o(), .sda_oe_o(sda_oe));
   imr_slave_model i_imr_slave_model (.scl_i(scl_ln), .sda_i(sda_ln), .scl_pull_o(scl_p),
      .sda_pull_o(sda_p), .slow_i(slow), .tx_i(tx), .addr_o(addr_seen));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   // one-cycle command pulse
   task go(input int k);
      @(posedge clk_sys_i);
      case (k)
         0: s_en <= 1;
         1: r_en <= 1;
         2: a_en <= 1;
         3: p_en <= 1;
         4: wr <= 1;
         5: rd <= 1;
         6: i_clr <= 1;
         7: o_clr <= 1;
         default: w_clr <= 1;
      endcase
      @(posedge clk_sys_i);
      {s_en, r_en, a_en, p_en, wr, rd, i_clr, o_clr, w_clr} <= '0;
   endtask
   task wait_int;
      for (int n = 0; n < 4000 && irq !== 1; n++) @(posedge clk_sys_i);
      check(irq, 1);
      go(6);
   endtask
   // one byte: mode 1 stalls on a full fifo, mode 2 collides a write
   task rx(input bit rdit, input bit nack, input int mode);
      logic [7:0] v;
      go(1);
      if (mode == 2)
      begin
         go(4);
         @(posedge clk_sys_i);
         check(write_collision_flag, 1);
         go(8);
      end
      if (mode == 1)
      begin
         repeat (300) @(posedge clk_sys_i);
         check(irq, 0);
         check(busy, 1);
         go(5);
      end
      wait_int;
      if (rdit)
         go(5);
      v = rnd();
      tx <= v;
      if (!nack)
         q.push_back(v);
      slow <= seed[9];
      a_d <= nack;
      go(2);
      wait_int;
   endtask
   task tally_and_finish;
      if (error_cnt == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // ------------------------------------------------------------
   // checking and stimulus
   // ------------------------------------------------------------
   // each read takes the oldest queued byte
   always @(posedge clk_sys_i)
      if (rd === 1)
         check(dbuf, q.pop_front());
   // watchdog well past the expected run length
   initial
   begin
      #400000;
      error_cnt++;
      tally_and_finish;
   end
   initial
   begin
      logic [7:0] a, b;
      repeat (16) @(posedge clk_sys_i);
      arst_n_i <= 1;
      go(0);
      go(1);
      wait_int;
      check(receive_enable_bit, 0);
      a = rnd() | 8'h01;
      b = rnd();
      wdat <= a;
      tx <= b;
      q.push_back(b);
      go(4);
      wait_int;
      check(addr_seen, a);
      check(ackst, 0);
      rx(1, 0, 2);
      rx(1, 0, 0);
      for (int i = 0; i < 16; i++) rx(0, 0, 0);
      check(ovf, 1);
      go(7);
      rx(0, 0, 1);
      for (int i = 0; i < 20 && rxav === 1; i++)
      begin
         go(5);
         repeat (2) @(posedge clk_sys_i);
      end
      check(bf, 0);
      check(8'(q.size()), 8'h01);
      rx(1, 1, 0);
      go(3);
      wait_int;
      check({scl_ln, sda_ln}, 8'h03);
      check(busy, 0);
      tally_and_finish;
   end
endmodule
bind imr_master_rx imr_monitor i_imr_monitor (.clk_sys_i, .arst_n_i, .receive_enable_bit_i,
   .buf_wr_i, .buf_rd_i, .ack_data_bit_i, .port_data_buffer_o, .buffer_full_flag_o,
   .port_interrupt_flag_o, .receive_overflow_flag_o, .write_collision_flag_o,
   .receive_enable_bit_o, .start_enable_bit_o, .ack_sequence_enable_o, .scl_oe_o, .sda_oe_o);
